/* File: rtl/dscd_pkg.sv */
package dscd_pkg;
   // Frame layout
   localparam int FRAME_BITS = 16;
   localparam int PAYLOAD_BITS = 12;
   localparam int RW_POS = 15;
   localparam int SEL_MSB = 14;
   localparam int SEL_LSB = 12;
   // Rising edges seen before readback drive begins (drive on the fifth)
   localparam logic [4:0] READ_START_COUNT = 5'h04;
   localparam logic [4:0] FRAME_COUNT = 5'h10;
   // Register select codes
   localparam logic [2:0] SEL_NOP = 3'h0;
   localparam logic [2:0] SEL_DAC_INPUT = 3'h1;
   localparam logic [2:0] SEL_CONTROL = 3'h7;
   // Control field positions
   localparam int CTRL_THERMAL_POS = 0;
   localparam int CTRL_POWER_POS = 2;
   localparam int CTRL_FLOAT_POS = 6;
   // Reset values
   localparam logic CTRL_POWER_RST = 1'b0;
   localparam logic CTRL_FLOAT_RST = 1'b1;
   localparam logic [11:0] DAC_INPUT_RST = 12'h000;

   typedef enum logic [1:0] {
      DSCD_IDLE = 2'b00,
      DSCD_SHIFT = 2'b01,
      DSCD_DONE = 2'b10
   } dscd_state_t;
endpackage

/* File: rtl/dscd_pin_if.sv */
`timescale 1ns/1ps
interface dscd_pin_if;
   logic sclk_rise;
   logic sclk_fall;
   logic frame_start;
   logic frame_active;
   logic sdi;
   logic over_temp;
   modport src (output sclk_rise, output sclk_fall, output frame_start, output frame_active,
      output sdi, output over_temp);
   modport dst (input sclk_rise, input sclk_fall, input frame_start, input frame_active,
      input sdi, input over_temp);
endinterface

/* File: rtl/dscd_pin_sync.sv */
`timescale 1ns/1ps
module dscd_pin_sync
   import dscd_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire logic sclk_i,
   input wire logic sync_n_i,
   input wire logic sdi_i,
   input wire logic over_temp_i,
   dscd_pin_if.src pins
);
   logic [3:0] stage1;
   logic [3:0] stage2;
   logic sclk_prev;
   logic sync_n_prev;
   logic [3:0] next_stage1;
   logic [3:0] next_stage2;
   logic next_sclk_prev;
   logic next_sync_n_prev;

   // Two-flop synchronisers, then edge history
   always_comb begin
      next_stage1 = {over_temp_i, sdi_i, sync_n_i, sclk_i};
      next_stage2 = stage1;
      next_sclk_prev = stage2[0];
      next_sync_n_prev = stage2[1];
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         stage1 <= 4'h2;
         stage2 <= 4'h2;
         sclk_prev <= 1'b0;
         sync_n_prev <= 1'b1;
      end else begin
         stage1 <= next_stage1;
         stage2 <= next_stage2;
         sclk_prev <= next_sclk_prev;
         sync_n_prev <= next_sync_n_prev;
      end
   end

   // Edge strobes from the second stage only
   assign pins.sclk_rise = stage2[0] & ~sclk_prev;
   assign pins.sclk_fall = ~stage2[0] & sclk_prev;
   assign pins.frame_start = ~stage2[1] & sync_n_prev;
   assign pins.frame_active = ~stage2[1];
   assign pins.sdi = stage2[2];
   assign pins.over_temp = stage2[3];
endmodule

/* File: rtl/dscd_top.sv */
`timescale 1ns/1ps
module dscd_top
   import dscd_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire logic sclk_i,
   input wire logic sync_n_i,
   input wire logic sdi_i,
   input wire logic over_temp_i,
   output logic sdo_o,
   output logic sdo_oe_o,
   output logic alarm_n_o,
   output logic [11:0] dac_input_value_o,
   output logic dac_input_write_o,
   output logic channel_power_up_o,
   output logic output_float_o,
   output logic analog_ground_load_o
);
   // Synchronised pin strobes shared with the pin stage
   dscd_pin_if pins ();

   dscd_pin_sync u_sync (
      .sys_clk_i(sys_clk_i),
      .srst_i(srst_i),
      .sclk_i(sclk_i),
      .sync_n_i(sync_n_i),
      .sdi_i(sdi_i),
      .over_temp_i(over_temp_i),
      .pins(pins)
   );

   // Frame sequencer state and serial shifters
   dscd_state_t state;
   dscd_state_t next_state;
   logic [15:0] frame_sh;
   logic [15:0] next_frame_sh;
   logic [4:0] edge_cnt;
   logic [4:0] next_edge_cnt;
   logic [11:0] out_sh;
   logic [11:0] next_out_sh;
   logic next_sdo;
   logic next_sdo_oe;

   // Control register bits and write strobe
   logic thermal_shutdown_flag;
   logic next_thermal;
   logic channel_power_up;
   logic next_power;
   logic powered_down_output_float;
   logic next_float;
   logic [11:0] next_dac_value;
   logic next_dac_write;

   // Readback and execution decode
   logic [11:0] read_data;
   logic execute;
   logic [2:0] exec_sel;
   logic channel_live;

   // Selected register image for readback
   function automatic logic [11:0] readback(input logic [2:0] sel, input logic [11:0] dac,
         input logic therm, input logic pwr, input logic flt);
      logic [11:0] ctrl;
      ctrl = 12'h000;
      ctrl[CTRL_THERMAL_POS] = therm;
      ctrl[CTRL_POWER_POS] = pwr;
      ctrl[CTRL_FLOAT_POS] = flt;
      case (sel)
         SEL_DAC_INPUT: readback = dac;
         SEL_CONTROL: readback = ctrl;
         default: readback = 12'h000;
      endcase
   endfunction

   // Edge counter comparison against a frame landmark
   function automatic logic count_reached(input logic [4:0] cnt, input logic [4:0] mark);
      count_reached = (cnt == mark);
   endfunction

   // Readback image and execute strobe
   assign read_data = readback(frame_sh[2:0], dac_input_value_o, thermal_shutdown_flag,
      channel_power_up, powered_down_output_float);
   assign execute = (state == DSCD_SHIFT) && pins.sclk_fall && count_reached(edge_cnt, FRAME_COUNT);
   assign exec_sel = frame_sh[SEL_MSB:SEL_LSB];

   // Frame sequencer and serial shifters
   always_comb begin
      next_state = state;
      next_frame_sh = frame_sh;
      next_edge_cnt = edge_cnt;
      next_out_sh = out_sh;
      next_sdo = sdo_o;
      next_sdo_oe = sdo_oe_o;
      case (state)
         DSCD_IDLE: begin
            next_sdo_oe = 1'b0;
            if (pins.frame_start) begin
               next_state = DSCD_SHIFT;
               next_edge_cnt = 5'h00;
            end
         end
         DSCD_SHIFT: begin
            if (!pins.frame_active) begin
               next_state = DSCD_IDLE;
               next_sdo_oe = 1'b0;
            end else if (pins.sclk_rise && !count_reached(edge_cnt, FRAME_COUNT)) begin
               next_frame_sh = {frame_sh[14:0], pins.sdi};
               next_edge_cnt = edge_cnt + 5'h01;
               if (count_reached(edge_cnt, READ_START_COUNT) && frame_sh[3]) begin
                  next_sdo_oe = 1'b1;
                  next_sdo = read_data[11];
                  next_out_sh = {read_data[10:0], 1'b0};
               end else if (sdo_oe_o) begin
                  next_sdo = out_sh[11];
                  next_out_sh = {out_sh[10:0], 1'b0};
               end
            end else if (execute) begin
               next_state = DSCD_DONE;
               next_sdo_oe = 1'b0;
            end
         end
         DSCD_DONE: begin
            next_sdo_oe = 1'b0;
            if (!pins.frame_active) begin
               next_state = DSCD_IDLE;
            end
         end
         default: begin
            next_state = DSCD_IDLE;
            next_sdo_oe = 1'b0;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         state <= DSCD_IDLE;
         frame_sh <= 16'h0000;
         edge_cnt <= 5'h00;
         out_sh <= 12'h000;
         sdo_o <= 1'b0;
         sdo_oe_o <= 1'b0;
      end else begin
         state <= next_state;
         frame_sh <= next_frame_sh;
         edge_cnt <= next_edge_cnt;
         out_sh <= next_out_sh;
         sdo_o <= next_sdo;
         sdo_oe_o <= next_sdo_oe;
      end
   end

   // Register writes at frame execution
   always_comb begin
      next_dac_value = dac_input_value_o;
      next_dac_write = 1'b0;
      next_power = channel_power_up;
      next_float = powered_down_output_float;
      next_thermal = thermal_shutdown_flag;
      if (execute && !frame_sh[RW_POS]) begin
         case (exec_sel)
            SEL_DAC_INPUT: begin
               next_dac_value = frame_sh[11:0];
               next_dac_write = 1'b1;
            end
            SEL_CONTROL: begin
               next_power = frame_sh[CTRL_POWER_POS];
               next_float = frame_sh[CTRL_FLOAT_POS];
               if (!frame_sh[CTRL_THERMAL_POS]) begin
                  next_thermal = 1'b0;
               end
            end
            default: begin
               next_dac_write = 1'b0;
            end
         endcase
      end
      // Over-temperature sets the flag and wins over a clearing write
      if (pins.over_temp) begin
         next_thermal = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         dac_input_value_o <= DAC_INPUT_RST;
         dac_input_write_o <= 1'b0;
         channel_power_up <= CTRL_POWER_RST;
         powered_down_output_float <= CTRL_FLOAT_RST;
         thermal_shutdown_flag <= 1'b0;
      end else begin
         dac_input_value_o <= next_dac_value;
         dac_input_write_o <= next_dac_write;
         channel_power_up <= next_power;
         powered_down_output_float <= next_float;
         thermal_shutdown_flag <= next_thermal;
      end
   end

   // Output stage control; shutdown acts as a power-down
   assign channel_live = channel_power_up & ~thermal_shutdown_flag;
   assign alarm_n_o = ~thermal_shutdown_flag;
   assign channel_power_up_o = channel_live;
   assign output_float_o = ~channel_live & powered_down_output_float;
   assign analog_ground_load_o = ~channel_live & ~powered_down_output_float;
endmodule

/* File: bench/dscd_top_sva.sv */
`timescale 1ns/1ps
module dscd_top_sva (
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire logic sync_n_i,
   input wire logic over_temp_i,
   input wire logic sdo_oe_o,
   input wire logic alarm_n_o,
   input wire logic [11:0] dac_input_value_o,
   input wire logic dac_input_write_o,
   input wire logic channel_power_up_o,
   input wire logic output_float_o,
   input wire logic analog_ground_load_o
);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (srst_i);
   // Thermal flag and alarm behaviour
   a_alarm_set: assert property (over_temp_i |-> ##[1:6] !alarm_n_o)
      else $error("alarm not raised");
   a_alarm_hold: assert property (!alarm_n_o && sync_n_i && $past(sync_n_i, 8) |=> !alarm_n_o)
      else $error("alarm cleared without a frame");
   a_hot_power: assert property (!alarm_n_o |-> !channel_power_up_o)
      else $error("channel up in shutdown");
   // Powered-down termination
   a_power_float: assert property (channel_power_up_o |-> !output_float_o && !analog_ground_load_o)
      else $error("termination active while up");
   a_down_term: assert property (!channel_power_up_o |-> output_float_o != analog_ground_load_o)
      else $error("termination not exclusive");
   // Serial output drive window
   a_oe_idle: assert property (sync_n_i && $past(sync_n_i, 6) |-> !sdo_oe_o)
      else $error("sdo driven outside frame");
   a_oe_start: assert property ($rose(sdo_oe_o) |-> !sync_n_i)
      else $error("sdo drive began without select");
   // Write execution
   a_pulse_one: assert property (dac_input_write_o |=> !dac_input_write_o)
      else $error("write pulse too long");
   a_no_idle_wr: assert property (sync_n_i && $past(sync_n_i, 8) |-> !dac_input_write_o)
      else $error("write outside frame");
   a_value_hold: assert property (!dac_input_write_o |-> $stable(dac_input_value_o))
      else $error("value changed without write");
endmodule
bind dscd_top dscd_top_sva u_sva (
   .sys_clk_i(sys_clk_i),
   .srst_i(srst_i),
   .sync_n_i(sync_n_i),
   .over_temp_i(over_temp_i),
   .sdo_oe_o(sdo_oe_o),
   .alarm_n_o(alarm_n_o),
   .dac_input_value_o(dac_input_value_o),
   .dac_input_write_o(dac_input_write_o),
   .channel_power_up_o(channel_power_up_o),
   .output_float_o(output_float_o),
   .analog_ground_load_o(analog_ground_load_o)
);

/* File: bench/dscd_host_model.sv */
`timescale 1ns/1ps
module dscd_host_model (
   input wire logic sys_clk_i,
   input wire logic sdo_i,
   input wire logic sdo_oe_i,
   output logic sclk_o,
   output logic sync_n_o,
   output logic sdi_o
);
   logic last = 1'b0;
   logic pin;
   // Released line shows inverse of last driven level
   always @(posedge sys_clk_i) begin
      if (sdo_oe_i === 1'b1) begin
         last <= sdo_i;
      end
   end
   assign pin = (sdo_oe_i === 1'b1) ? sdo_i : ~last;
   initial begin
      sclk_o = 1'b0;
      sync_n_o = 1'b1;
      sdi_o = 1'b0;
   end
   // One frame, MSB first, 200 ns serial clock, still outside it
   task automatic xfer(input logic [15:0] w, output logic [11:0] r);
      for (int i = 15; i >= 0; i--) begin
         @(posedge sys_clk_i);
         sync_n_o <= 1'b0;
         sdi_o <= w[i];
         repeat (3) @(posedge sys_clk_i);
         sclk_o <= 1'b1;
         repeat (4) @(posedge sys_clk_i);
         sclk_o <= 1'b0;
         @(negedge sys_clk_i);
         if (i < 12) begin
            r[i] = pin;
         end
      end
      repeat (6) @(posedge sys_clk_i);
      sync_n_o <= 1'b1;
      sdi_o <= ~sdi_o;
      repeat (8) @(posedge sys_clk_i);
   endtask
endmodule

/* File: bench/dac_serial_command_decode_tb_top.sv */
`timescale 1ns/1ps
module dac_serial_command_decode_tb_top;
   import dscd_pkg::*;
   logic sys_clk_i, srst_i, sclk_i, sync_n_i, sdi_i, over_temp_i, sdo_o, sdo_oe_o, alarm_n_o;
   logic dac_input_write_o, channel_power_up_o, output_float_o, analog_ground_load_o;
   logic [11:0] dac_input_value_o;
   int mismatches = 0, check_count = 0, cyc = 0, pulses = 0;
   dscd_top uut (.sys_clk_i, .srst_i, .sclk_i, .sync_n_i, .sdi_i, .over_temp_i, .sdo_o, .sdo_oe_o,
      .alarm_n_o, .dac_input_value_o, .dac_input_write_o, .channel_power_up_o, .output_float_o,
      .analog_ground_load_o);
   dscd_host_model host (.sys_clk_i, .sdo_i(sdo_o), .sdo_oe_i(sdo_oe_o), .sclk_o(sclk_i),
      .sync_n_o(sync_n_i), .sdi_o(sdi_i));
   initial begin
      sys_clk_i = 1'b0;
      forever #12.5 sys_clk_i = ~sys_clk_i;
   end
   // Write pulse counter and hang guard
   always @(posedge sys_clk_i) begin
      if (dac_input_write_o === 1'b1) pulses++;
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [15:0] w);
      logic [11:0] d;
      host.xfer(w, d);
   endtask
   task automatic rd(input string n, input logic [2:0] s, input logic [11:0] e);
      logic [11:0] d;
      host.xfer({1'b1, s, 12'h000}, d);
      chk(n, e, d);
   endtask
   // Main sequence
   initial begin
      srst_i = 1'b1;
      over_temp_i = 1'b0;
      repeat (16) @(posedge sys_clk_i);
      srst_i <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
      chk("power", 12'h000, {11'h000, channel_power_up_o});
      chk("float", 12'h001, {11'h000, output_float_o});
      rd("ctrl_rst", SEL_CONTROL, 12'h040);
      $display("test reset done");
      wr(16'h1a5c);
      chk("dac", 12'ha5c, dac_input_value_o);
      rd("dac_rd", SEL_DAC_INPUT, 12'ha5c);
      for (int s = 2; s < 7; s++) begin
         wr({1'b0, 3'(s), 12'h0a4});
         rd("rsv_rd", 3'(s), 12'h000);
      end
      chk("rsv_pwr", 12'h000, {11'h000, channel_power_up_o});
      chk("rsv_float", 12'h001, {11'h000, output_float_o});
      wr(16'h0fff);
      chk("nop_pwr", 12'h000, {11'h000, channel_power_up_o});
      chk("dac_kept", 12'ha5c, dac_input_value_o);
      chk("pulses", 12'h001, 12'(pulses));
      $display("test decode done");
      wr(16'h7004);
      wr(16'h0000);
      chk("pwr_up", 12'h001, {11'h000, channel_power_up_o});
      rd("ctrl_up", SEL_CONTROL, 12'h004);
      wr(16'h7000);
      wr(16'h0000);
      chk("gnd", 12'h001, {11'h000, analog_ground_load_o});
      wr(16'h7044);
      wr(16'h1000);
      $display("test control done");
      over_temp_i <= 1'b1;
      repeat (10) @(posedge sys_clk_i);
      over_temp_i <= 1'b0;
      repeat (10) @(posedge sys_clk_i);
      chk("alarm", 12'h000, {11'h000, alarm_n_o});
      chk("hot_pwr", 12'h000, {11'h000, channel_power_up_o});
      rd("ctrl_hot", SEL_CONTROL, 12'h045);
      wr(16'h7044);
      wr(16'h0000);
      chk("alarm_clr", 12'h001, {11'h000, alarm_n_o});
      rd("ctrl_cool", SEL_CONTROL, 12'h044);
      $display("test thermal done");
      give_verdict();
   end
endmodule
